// >>> dv/udec_ctrl_tb_top.sv
/*
  Bench top: firmware-side stimulus on plain ports, host stand-in on the bus.
  Assumes shortened line counts; every input changes on a falling edge.
*/
module udec_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SUSP = 400;
  logic I_CLK, I_NRST, I_CONTROLLER_ENABLE_BIT, I_CLOCK_FREEZE_BIT, I_DETACH_WR, I_DETACH_VAL, I_CPU_RESET_ON_BUS_RESET_BIT_WR, I_CPU_RESET_ON_BUS_RESET_BIT_VAL;
  logic I_REMOTE_WAKE_BIT_SET, I_ADDR_WR, I_ADDRESS_ENABLE_BIT_WR, I_ADDRESS_ENABLE_BIT_VAL, I_EP_EN_WR, I_EP_EN_VAL, I_CFG_WR;
  logic I_STALL_SET, I_STALL_CLR, I_TOGGLE_CLR, I_EOR_OK, I_DP, I_DM, cpu_rst_seen;
  logic O_HSK_VALID, O_PULLUP_EN, O_RESUME_DRV, O_CPU_RST, O_EP_IRQ_REQ, O_GEN_IRQ;
  logic [6:0] I_ADDR_VAL;
  logic [2:0] I_EP_SEL;
  logic [4:0] I_EP_RST, O_EP_IRQ;
  udec_pkg::udec_cfgw_t   I_CFG_VAL;
  udec_pkg::udec_epflg_t  I_FLAG_CLR, I_EP_IRQ_EN, O_SEL_FLAGS;
  udec_pkg::udec_genflg_t I_GEN_FLAG_CLR, I_GEN_IRQ_EN, O_GEN_FLAGS;
  udec_pkg::udec_tok_t    I_TOK;
  udec_pkg::udec_hsk_t    O_HSK;
  udec_pkg::udec_sts_t    O_SEL_STATUS;
  int n_fail = 0;
  int n_tests = 0;
  // Short counts keep the run small
  udec_ctrl #(.BUS_RST_CYC(20), .SUSP_CYC(SUSP), .RWK_CYC(600), .RESUME_CYC(10)) u_udec_ctrl (
    .I_CLK, .I_NRST, .I_DP, .I_DM, .I_CONTROLLER_ENABLE_BIT, .I_CLOCK_FREEZE_BIT, .I_DETACH_WR, .I_DETACH_VAL,
    .I_CPU_RESET_ON_BUS_RESET_BIT_WR, .I_CPU_RESET_ON_BUS_RESET_BIT_VAL, .I_REMOTE_WAKE_BIT_SET, .I_ADDR_WR, .I_ADDR_VAL, .I_ADDRESS_ENABLE_BIT_WR,
    .I_ADDRESS_ENABLE_BIT_VAL, .I_EP_SEL, .I_EP_RST, .I_EP_EN_WR, .I_EP_EN_VAL, .I_CFG_WR, .I_CFG_VAL,
    .I_STALL_SET, .I_STALL_CLR, .I_TOGGLE_CLR, .I_FLAG_CLR, .I_EP_IRQ_EN, .I_GEN_FLAG_CLR,
    .I_GEN_IRQ_EN, .I_TOK, .I_EOR_OK, .O_HSK_VALID, .O_HSK, .O_PULLUP_EN, .O_RESUME_DRV,
    .O_CPU_RST, .O_SEL_FLAGS, .O_SEL_STATUS, .O_GEN_FLAGS, .O_EP_IRQ, .O_EP_IRQ_REQ, .O_GEN_IRQ);
  udec_host_model u_udec_host_model (.i_clk(I_CLK), .o_dp(I_DP), .o_dm(I_DM), .o_tok(I_TOK));
  initial I_CLK = 1'h0;
  always #2 I_CLK = ~I_CLK;
  // One-cycle pulse, so latch it for a later look
  always @(posedge I_CLK) if (O_CPU_RST === 1'h1) cpu_rst_seen <= 1'h1;
  task automatic summarize;
    $display("Checks %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : summarize
  task automatic chk(input logic got, input logic exp, input string what);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t %s: got %b", $time, what, got);
    end
  endtask : chk
  task automatic wait_n(input int n);
    repeat (n) @(negedge I_CLK);
  endtask : wait_n
  task automatic tok(input udec_pkg::udec_pid_t p, input logic [6:0] a, input logic r,
                     input udec_pkg::udec_hsk_t h);
    // Handshake stands for one cycle only: look at it right after the taking edge
    u_udec_host_model.send(p, a, r);
    n_tests++;
    if (O_HSK_VALID !== (h != udec_pkg::HSK_NONE) || O_HSK !== h) begin
      n_fail++;
      $display("[ERR] %0t handshake %s, expected %s", $time, O_HSK.name(), h.name());
    end
  endtask : tok
  // Strobes drop after one edge, then the outputs get two edges to follow
  task automatic fw_done;
    wait_n(1);
    {I_DETACH_WR, I_CPU_RESET_ON_BUS_RESET_BIT_WR, I_ADDR_WR, I_ADDRESS_ENABLE_BIT_WR, I_EP_EN_WR, I_CFG_WR} = '0;
    {I_STALL_SET, I_STALL_CLR, I_EP_RST, I_FLAG_CLR, I_GEN_FLAG_CLR} = '0;
    wait_n(2);
  endtask : fw_done
  task automatic ep0_on;
    {I_EP_EN_WR, I_EP_EN_VAL, I_CFG_WR} = 3'h7;
    I_CFG_VAL = '{ctrl: 1'h1, memory_reserve_bit: 1'h1, banks2: 1'h0, size: 3'h0};
    fw_done;
  endtask : ep0_on
  task automatic s_stall;
    tok(udec_pkg::PID_SETUP, 7'h00, 1'h0, udec_pkg::HSK_ACK);
    wait_n(2);
    chk(O_SEL_FLAGS.setup_rx, 1'h1, "setup flag");
    chk(O_SEL_FLAGS.out_rx | O_SEL_STATUS.bank_access | O_SEL_STATUS.handover, 1'h0, "ctl");
    I_STALL_SET = 1'h1;
    fw_done;
    tok(udec_pkg::PID_OUT, 7'h00, 1'h1, udec_pkg::HSK_NAK);
    tok(udec_pkg::PID_OUT, 7'h00, 1'h0, udec_pkg::HSK_STALL);
    tok(udec_pkg::PID_IN, 7'h00, 1'h0, udec_pkg::HSK_STALL);
    wait_n(2);
    chk(O_SEL_FLAGS.stall_sent & ~O_SEL_FLAGS.out_rx, 1'h1, "stall sent");
    chk(O_EP_IRQ[0] & O_EP_IRQ_REQ, 1'h1, "endpoint irq");
    I_EP_RST = 5'h01;
    fw_done;
    chk(O_SEL_FLAGS.stall_sent | O_SEL_FLAGS.setup_rx, 1'h0, "ep reset flags");
    chk(O_SEL_STATUS.enabled & O_SEL_STATUS.toggle, 1'h1, "ep reset keeps");
    tok(udec_pkg::PID_SETUP, 7'h00, 1'h0, udec_pkg::HSK_ACK);
    wait_n(2);
    chk(O_SEL_STATUS.stall_rq | O_SEL_FLAGS.in_ready, 1'h0, "setup unstalls");
    I_STALL_SET = 1'h1;
    fw_done;
    I_STALL_CLR = 1'h1;
    fw_done;
    chk(O_SEL_STATUS.stall_rq, 1'h0, "stall clear");
    tok(udec_pkg::PID_OUT, 7'h00, 1'h0, udec_pkg::HSK_ACK);
  endtask : s_stall
  task automatic s_addr_reset;
    {I_ADDR_WR, I_ADDR_VAL} = 8'h85;
    fw_done;
    tok(udec_pkg::PID_OUT, 7'h05, 1'h0, udec_pkg::HSK_NONE);
    {I_ADDRESS_ENABLE_BIT_WR, I_ADDRESS_ENABLE_BIT_VAL, I_CPU_RESET_ON_BUS_RESET_BIT_WR, I_CPU_RESET_ON_BUS_RESET_BIT_VAL} = 4'hF;
    fw_done;
    tok(udec_pkg::PID_OUT, 7'h00, 1'h0, udec_pkg::HSK_NONE);
    tok(udec_pkg::PID_OUT, 7'h05, 1'h0, udec_pkg::HSK_NAK);
    u_udec_host_model.line(1'h0, 1'h0, 40);
    wait_n(2);
    chk(O_SEL_STATUS.enabled | O_SEL_STATUS.toggle, 1'h0, "bus reset ep0");
    chk(O_SEL_STATUS.cfg_ok & cpu_rst_seen, 1'h1, "cfg kept, cpu reset");
    tok(udec_pkg::PID_OUT, 7'h00, 1'h0, udec_pkg::HSK_NONE);
    ep0_on;
    tok(udec_pkg::PID_OUT, 7'h00, 1'h0, udec_pkg::HSK_ACK);
  endtask : s_addr_reset
  task automatic s_suspend;
    I_GEN_IRQ_EN.suspend = 1'h1;
    wait_n(SUSP + 10);
    chk(O_GEN_FLAGS.suspend & O_GEN_IRQ, 1'h1, "suspend");
    chk(O_GEN_FLAGS.wake, 1'h0, "wake after suspend");
    I_CLOCK_FREEZE_BIT = 1'h1;
    u_udec_host_model.line(1'h0, 1'h1, 4);
    wait_n(4);
    chk(O_GEN_FLAGS.wake & ~O_GEN_FLAGS.suspend, 1'h1, "wake");
    tok(udec_pkg::PID_IN, 7'h00, 1'h0, udec_pkg::HSK_NONE);
    I_CLOCK_FREEZE_BIT = 1'h0;
    wait_n(4);
    I_GEN_FLAG_CLR.wake = 1'h1;
    fw_done;
    chk(O_GEN_FLAGS.wake | O_GEN_IRQ, 1'h0, "wake cleared");
    wait_n(SUSP + 10);
    I_REMOTE_WAKE_BIT_SET = 1'h1;
    fw_done;
    I_REMOTE_WAKE_BIT_SET = 1'h0;
    wait_n(250);
    chk(O_GEN_FLAGS.up_resume & ~O_GEN_FLAGS.suspend & ~O_RESUME_DRV, 1'h1, "resume");
  endtask : s_suspend
  initial begin
    {I_NRST, I_CLOCK_FREEZE_BIT, I_DETACH_WR, I_DETACH_VAL, I_CPU_RESET_ON_BUS_RESET_BIT_WR, I_CPU_RESET_ON_BUS_RESET_BIT_VAL, I_REMOTE_WAKE_BIT_SET} = '0;
    {I_ADDR_WR, I_ADDR_VAL, I_ADDRESS_ENABLE_BIT_WR, I_ADDRESS_ENABLE_BIT_VAL, I_EP_SEL, I_EP_RST, I_EP_EN_WR} = '0;
    {I_EP_EN_VAL, I_CFG_WR, I_CFG_VAL, I_STALL_SET, I_STALL_CLR, I_TOGGLE_CLR, I_EOR_OK} = '0;
    {I_FLAG_CLR, I_GEN_FLAG_CLR, I_GEN_IRQ_EN, cpu_rst_seen} = '0;
    I_EP_IRQ_EN = '{stall_sent: 1'h1, default: 1'h0};
    I_CONTROLLER_ENABLE_BIT = 1'h1;
    wait_n(2);
    I_NRST = 1'h1;
    wait_n(1);
    chk(O_PULLUP_EN, 1'h0, "detached after reset");
    I_DETACH_WR = 1'h1;
    fw_done;
    chk(O_PULLUP_EN, 1'h1, "attached");
    ep0_on;
    s_stall;
    s_addr_reset;
    s_suspend;
    summarize;
  end
  initial begin
    #20000;
    n_fail++;
    $display("[ERR] %0t watchdog expired", $time);
    summarize;
  end
endmodule : udec_ctrl_tb_top

// >>> dv/udec_host_model.sv
/*
  Host stand-in on the full-speed bus: line levels and decoded tokens.
  Assumes its tasks are called at a falling edge of the shared clock.
*/
module udec_host_model (
  input  wire logic           i_clk,
  output logic                o_dp,
  output logic                o_dm,
  output udec_pkg::udec_tok_t o_tok
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_dp  = 1'h1;
    o_dm  = 1'h0;
    o_tok = '0;
  end
  // Hold a line state, then fall back to idle J
  task automatic line(input logic dp, input logic dm, input int n);
    o_dp = dp;
    o_dm = dm;
    repeat (n) @(negedge i_clk);
    o_dp = 1'h1;
    o_dm = 1'h0;
  endtask : line
  // K burst stands for packet activity, then a one-cycle token
  task automatic send(input udec_pkg::udec_pid_t p, input logic [6:0] a, input logic r);
    line(1'h0, 1'h1, 2);
    o_tok = '{valid: 1'h1, pid: p, ep: 3'h0, addr: a, zlp: 1'h0, len: 7'h08,
              retry: r, setup_in: 1'h0};
    @(negedge i_clk);
    o_tok = '0;
  endtask : send
endmodule : udec_host_model

// >>> hdl/udec_ctrl.sv
/*
  Endpoint control, addressing, suspend, resume and stall logic of a full-speed device.
  Assumes a same-clock packet engine delivering decoded tokens and firmware as plain ports.
*/
module udec_ctrl #(
  parameter int BUS_RST_CYC = udec_pkg::BUS_RST_CYC,
  parameter int SUSP_CYC    = udec_pkg::SUSP_CYC,
  parameter int RWK_CYC     = udec_pkg::RWK_CYC,
  parameter int RESUME_CYC  = udec_pkg::RESUME_CYC
) (
  input  wire logic                      I_CLK,
  input  wire logic                      I_NRST,
  input  wire logic                      I_DP,
  input  wire logic                      I_DM,
  input  wire logic                      I_CONTROLLER_ENABLE_BIT,
  input  wire logic                      I_CLOCK_FREEZE_BIT,
  input  wire logic                      I_DETACH_WR,
  input  wire logic                      I_DETACH_VAL,
  input  wire logic                      I_CPU_RESET_ON_BUS_RESET_BIT_WR,
  input  wire logic                      I_CPU_RESET_ON_BUS_RESET_BIT_VAL,
  input  wire logic                      I_REMOTE_WAKE_BIT_SET,
  input  wire logic                      I_ADDR_WR,
  input  wire logic [udec_pkg::ADDR_W-1:0] I_ADDR_VAL,
  input  wire logic                      I_ADDRESS_ENABLE_BIT_WR,
  input  wire logic                      I_ADDRESS_ENABLE_BIT_VAL,
  input  wire logic [udec_pkg::EP_W-1:0] I_EP_SEL,
  input  wire logic [udec_pkg::EP_NUM-1:0] I_EP_RST,
  input  wire logic                      I_EP_EN_WR,
  input  wire logic                      I_EP_EN_VAL,
  input  wire logic                      I_CFG_WR,
  input  wire udec_pkg::udec_cfgw_t      I_CFG_VAL,
  input  wire logic                      I_STALL_SET,
  input  wire logic                      I_STALL_CLR,
  input  wire logic                      I_TOGGLE_CLR,
  input  wire udec_pkg::udec_epflg_t     I_FLAG_CLR,
  input  wire udec_pkg::udec_epflg_t     I_EP_IRQ_EN,
  input  wire udec_pkg::udec_genflg_t    I_GEN_FLAG_CLR,
  input  wire udec_pkg::udec_genflg_t    I_GEN_IRQ_EN,
  input  wire udec_pkg::udec_tok_t       I_TOK,
  input  wire logic                      I_EOR_OK,
  output logic                           O_HSK_VALID,
  output udec_pkg::udec_hsk_t            O_HSK,
  output logic                           O_PULLUP_EN,
  output logic                           O_RESUME_DRV,
  output logic                           O_CPU_RST,
  output udec_pkg::udec_epflg_t          O_SEL_FLAGS,
  output udec_pkg::udec_sts_t            O_SEL_STATUS,
  output udec_pkg::udec_genflg_t         O_GEN_FLAGS,
  output logic [udec_pkg::EP_NUM-1:0]    O_EP_IRQ,
  output logic                           O_EP_IRQ_REQ,
  output logic                           O_GEN_IRQ
);
  localparam int N = udec_pkg::EP_NUM;
  localparam int CW = udec_pkg::CNT_W;

  logic [1:0]                 line_s;
  logic                       line_j_q_reg;
  logic [CW-1:0]              idle_cnt_reg;
  logic [CW-1:0]              se0_cnt_reg;
  logic [CW-1:0]              rsm_cnt_reg;
  logic                       rsm_active_reg;
  logic                       eor_armed_reg;
  logic                       rmwk_reg;
  logic                       cpu_reset_on_bus_reset_bit_reg;
  logic [udec_pkg::ADDR_W-1:0] device_address_field_reg;
  logic                       addren_reg;
  logic [N-1:0]               en_reg;
  logic [N-1:0]               en_next;
  udec_pkg::udec_genflg_t     gen_reg;
  udec_pkg::udec_genflg_t     gen_next;
  udec_pkg::udec_ep_t         st_reg  [N];
  udec_pkg::udec_ep_t         st_next [N];
  udec_pkg::udec_cfg_t        cfg_reg [N];
  udec_pkg::udec_hsk_t        hsk_ep  [N];
  logic [N-1:0]               ep_irq;

  udec_sync3 #(.W(2)) u_line_sync (
    .i_clk  (I_CLK),
    .i_nrst (I_NRST),
    .i_d    ({I_DP, I_DM}),
    .o_q    (line_s)
  );

  // Line conditions and timers
  wire line_j    = (line_s == udec_pkg::LINE_J);
  wire line_se0  = (line_s == udec_pkg::LINE_SE0);
  wire bus_rst   = line_se0 && (se0_cnt_reg == CW'(BUS_RST_CYC - 1));
  wire susp_hit  = line_j && (idle_cnt_reg == CW'(SUSP_CYC - 1));
  // Own resume drive is not taken as host activity
  wire wake_hit  = line_j_q_reg && !line_j && !rsm_active_reg;
  wire rsm_start = rmwk_reg && !rsm_active_reg && (idle_cnt_reg == CW'(RWK_CYC));
  wire rsm_end   = rsm_active_reg && (rsm_cnt_reg == CW'(RESUME_CYC - 1));
  wire idle_sat  = (idle_cnt_reg == CW'(RWK_CYC));

  // Address filter and token acceptance
  wire addr_ok = addren_reg ? (I_TOK.addr == device_address_field_reg)
                            : (I_TOK.addr == udec_pkg::ADDR_DEFAULT);
  wire tok_ok  = I_TOK.valid && !I_CLOCK_FREEZE_BIT && addr_ok && (I_TOK.ep < udec_pkg::EP_W'(N));
  wire cfg_ok_new = I_CFG_VAL.memory_reserve_bit
                 && (udec_pkg::ep_bytes(I_CFG_VAL) <= 9'(udec_pkg::DPRAM_BYTES));

  wire udec_pkg::udec_hsk_t hsk_next = tok_ok ? hsk_ep[I_TOK.ep] : udec_pkg::HSK_NONE;
  wire udec_pkg::udec_cfg_t sel_cfg = cfg_reg[I_EP_SEL];
  wire udec_pkg::udec_ep_t  sel_st  = st_reg[I_EP_SEL];
  // Control endpoints report no bank handover or access
  wire sel_bank = !sel_cfg.w.ctrl && (sel_st.flags.out_rx || sel_st.flags.in_ready);

  always_comb begin
    gen_next = gen_reg & ~I_GEN_FLAG_CLR;
    if (susp_hit) begin
      gen_next.suspend = 1'b1;
      gen_next.wake    = 1'b0;
    end
    if (wake_hit) begin
      gen_next.wake    = 1'b1;
      gen_next.suspend = 1'b0;
    end
    if (rsm_start) begin
      gen_next.up_resume = 1'b1;
      gen_next.suspend   = 1'b0;
    end
    if (I_EOR_OK && eor_armed_reg) begin
      gen_next.end_resume = 1'b1;
    end
  end

  always_comb begin
    en_next = en_reg;
    if (I_EP_EN_WR) begin
      en_next[I_EP_SEL] = I_EP_EN_VAL;
    end
    if (bus_rst) begin
      en_next = '0;
    end
  end

  for (genvar g = 0; g < N; g++) begin : g_ep
    wire sel     = (I_EP_SEL == udec_pkg::EP_W'(g));
    wire hit     = tok_ok && (I_TOK.ep == udec_pkg::EP_W'(g)) && en_reg[g];
    wire disable_now = !en_reg[g] || (sel && I_EP_EN_WR && !I_EP_EN_VAL);
    wire do_rst  = I_EP_RST[g] || disable_now;
    udec_pkg::udec_ep_t  s;
    udec_pkg::udec_hsk_t h;
    udec_pkg::udec_epflg_t clr;

    always_comb begin
      s   = st_reg[g];
      h   = udec_pkg::HSK_NONE;
      clr = sel ? I_FLAG_CLR : '0;
      if (s.cst == udec_pkg::CTL_STATUS) begin
        clr.in_ready = 1'b0;
      end
      s.flags = s.flags & ~clr;
      if (sel && I_STALL_SET) begin
        s.stall = 1'b1;
      end
      if (sel && I_STALL_CLR) begin
        s.stall = 1'b0;
      end
      if (sel && I_TOGGLE_CLR) begin
        s.toggle = 1'b0;
      end
      if (hit) begin
        if (I_TOK.pid == udec_pkg::PID_SETUP && cfg_reg[g].w.ctrl) begin
          h = udec_pkg::HSK_ACK;
          s.flags.setup_rx   = 1'b1;
          s.flags.stall_sent = 1'b0;
          s.flags.in_ready   = 1'b0;
          s.stall  = 1'b0;
          s.toggle = 1'b1;
          s.cst    = I_TOK.setup_in ? udec_pkg::CTL_READ : udec_pkg::CTL_IDLE;
          s.bcnt   = I_TOK.zlp ? '0 : I_TOK.len;
        end else if (!cfg_reg[g].ok) begin
          h = udec_pkg::HSK_NONE;
        end else if (I_TOK.retry) begin
          h = udec_pkg::HSK_NAK;
        end else if (s.stall) begin
          h = udec_pkg::HSK_STALL;
          s.flags.stall_sent = 1'b1;
        end else if (I_TOK.pid == udec_pkg::PID_OUT && s.cst == udec_pkg::CTL_READ) begin
          // Unsent CPU data is dropped: bank marked free again
          h = udec_pkg::HSK_NAK;
          s.cst = udec_pkg::CTL_STATUS;
          s.flags.in_ready = 1'b1;
        end else if (I_TOK.pid == udec_pkg::PID_OUT && s.cst == udec_pkg::CTL_STATUS) begin
          h = udec_pkg::HSK_ACK;
          s.flags.out_rx   = 1'b1;
          s.flags.in_ready = 1'b1;
          s.bcnt = I_TOK.zlp ? '0 : I_TOK.len;
        end else if (I_TOK.pid == udec_pkg::PID_OUT) begin
          h = s.flags.out_rx ? udec_pkg::HSK_NAK : udec_pkg::HSK_ACK;
          if (!s.flags.out_rx) begin
            s.flags.out_rx = 1'b1;
            s.bcnt   = I_TOK.zlp ? '0 : I_TOK.len;
            s.toggle = !s.toggle;
          end
        end else if (I_TOK.pid == udec_pkg::PID_IN) begin
          h = s.flags.in_ready ? udec_pkg::HSK_NAK : udec_pkg::HSK_ACK;
          s.flags.nak_in   = s.flags.nak_in | s.flags.in_ready;
          s.toggle         = s.toggle ^ !s.flags.in_ready;
          s.flags.in_ready = 1'b1;
        end
      end
      if (do_rst) begin
        s.flags = '0;
        s.cst   = udec_pkg::CTL_IDLE;
        s.bcnt  = '0;
      end
      if (disable_now) begin
        s.toggle = 1'b0;
      end
      if (bus_rst && g == 0) begin
        s.toggle = 1'b0;
      end
    end

    assign st_next[g] = s;
    assign hsk_ep[g]  = h;
    assign ep_irq[g]  = |(st_reg[g].flags & I_EP_IRQ_EN);
  end

  // Controller falls back to reset values while disabled, except the line sync and the idle and SE0 timers
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      for (int i = 0; i < N; i++) begin
        st_reg[i]  <= '0;
        cfg_reg[i] <= '0;
      end
      en_reg <= '0;
    end else begin
      for (int i = 0; i < N; i++) begin
        st_reg[i] <= I_CONTROLLER_ENABLE_BIT ? st_next[i] : '0;
        if (!I_CONTROLLER_ENABLE_BIT) begin
          cfg_reg[i] <= '0;
        end else if (I_CFG_WR && I_EP_SEL == udec_pkg::EP_W'(i)) begin
          cfg_reg[i] <= '{w: I_CFG_VAL, ok: cfg_ok_new};
        end
      end
      en_reg <= I_CONTROLLER_ENABLE_BIT ? en_next : '0;
    end
  end

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      line_j_q_reg   <= 1'b0;
      idle_cnt_reg   <= '0;
      se0_cnt_reg    <= '0;
      rsm_cnt_reg    <= '0;
      rsm_active_reg <= 1'b0;
      eor_armed_reg  <= 1'b0;
      gen_reg        <= '0;
    end else begin
      line_j_q_reg   <= line_j;
      idle_cnt_reg   <= (!line_j || rsm_active_reg) ? '0 : (idle_sat ? idle_cnt_reg
                                                                     : idle_cnt_reg + 1'b1);
      se0_cnt_reg    <= (!line_se0 || bus_rst) ? '0 : se0_cnt_reg + 1'b1;
      rsm_cnt_reg    <= rsm_active_reg && !rsm_end ? rsm_cnt_reg + 1'b1 : '0;
      rsm_active_reg <= I_CONTROLLER_ENABLE_BIT && (rsm_start || (rsm_active_reg && !rsm_end));
      eor_armed_reg  <= I_CONTROLLER_ENABLE_BIT && (rsm_end || (eor_armed_reg && !I_EOR_OK));
      gen_reg        <= I_CONTROLLER_ENABLE_BIT ? gen_next : '0;
    end
  end

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      rmwk_reg    <= 1'b0;
      cpu_reset_on_bus_reset_bit_reg  <= 1'b0;
      device_address_field_reg    <= udec_pkg::ADDR_DEFAULT;
      addren_reg  <= 1'b0;
      O_PULLUP_EN <= 1'b0;
    end else if (!I_CONTROLLER_ENABLE_BIT) begin
      rmwk_reg    <= 1'b0;
      cpu_reset_on_bus_reset_bit_reg  <= 1'b0;
      device_address_field_reg    <= udec_pkg::ADDR_DEFAULT;
      addren_reg  <= 1'b0;
      O_PULLUP_EN <= 1'b0;
    end else begin
      // Zero writes ignored; only the end of resume drops it
      rmwk_reg   <= rsm_end ? 1'b0 : (rmwk_reg || (I_REMOTE_WAKE_BIT_SET && gen_reg.suspend));
      cpu_reset_on_bus_reset_bit_reg <= I_CPU_RESET_ON_BUS_RESET_BIT_WR ? I_CPU_RESET_ON_BUS_RESET_BIT_VAL : cpu_reset_on_bus_reset_bit_reg;
      device_address_field_reg   <= bus_rst ? udec_pkg::ADDR_DEFAULT : (I_ADDR_WR ? I_ADDR_VAL : device_address_field_reg);
      addren_reg <= bus_rst ? 1'b0 : (I_ADDRESS_ENABLE_BIT_WR ? I_ADDRESS_ENABLE_BIT_VAL : addren_reg);
      O_PULLUP_EN <= I_DETACH_WR ? !I_DETACH_VAL : O_PULLUP_EN;
    end
  end

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_HSK_VALID  <= 1'b0;
      O_HSK        <= udec_pkg::HSK_NONE;
      O_RESUME_DRV <= 1'b0;
      O_CPU_RST    <= 1'b0;
      O_SEL_FLAGS  <= '0;
      O_SEL_STATUS <= '0;
      O_GEN_FLAGS  <= '0;
      O_EP_IRQ     <= '0;
      O_EP_IRQ_REQ <= 1'b0;
      O_GEN_IRQ    <= 1'b0;
    end else begin
      O_HSK_VALID  <= I_CONTROLLER_ENABLE_BIT && (hsk_next != udec_pkg::HSK_NONE);
      O_HSK        <= I_CONTROLLER_ENABLE_BIT ? hsk_next : udec_pkg::HSK_NONE;
      O_RESUME_DRV <= I_CONTROLLER_ENABLE_BIT && (rsm_start || (rsm_active_reg && !rsm_end));
      O_CPU_RST    <= I_CONTROLLER_ENABLE_BIT && bus_rst && cpu_reset_on_bus_reset_bit_reg;
      O_SEL_FLAGS  <= sel_st.flags;
      O_SEL_STATUS <= '{enabled: en_reg[I_EP_SEL], cfg_ok: sel_cfg.ok,
                        toggle: sel_st.toggle, stall_rq: sel_st.stall,
                        bank_access: sel_bank, handover: sel_bank, bcnt: sel_st.bcnt};
      O_GEN_FLAGS  <= gen_reg;
      O_EP_IRQ     <= ep_irq;
      O_EP_IRQ_REQ <= |ep_irq;
      O_GEN_IRQ    <= |(gen_reg & I_GEN_IRQ_EN);
    end
  end

  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_NRST);

  a_setup_always_ack: assert property (
    I_CONTROLLER_ENABLE_BIT && tok_ok && en_reg[I_TOK.ep] && I_TOK.pid == udec_pkg::PID_SETUP
      && cfg_reg[I_TOK.ep].w.ctrl |=> O_HSK_VALID && O_HSK == udec_pkg::HSK_ACK)
    else $error("setup not acknowledged");
  a_addr_default_only: assert property (
    I_TOK.valid && !addren_reg && I_TOK.addr != udec_pkg::ADDR_DEFAULT |=> !O_HSK_VALID)
    else $error("answered foreign address while address disabled");
  a_bus_reset_clear: assert property (
    I_CONTROLLER_ENABLE_BIT && bus_rst |=> en_reg == '0 && !addren_reg && device_address_field_reg == udec_pkg::ADDR_DEFAULT
      && !st_reg[0].toggle)
    else $error("bus reset left endpoint or address state");
  a_stall_clear_now: assert property (
    I_CONTROLLER_ENABLE_BIT && I_STALL_CLR |=> !st_reg[$past(I_EP_SEL)].stall)
    else $error("stall request survived stall clear");
  a_susp_wake_excl: assert property (
    !(gen_reg.suspend && gen_reg.wake))
    else $error("suspend and wake flags both set");
  a_rmwk_hw_only: assert property (
    rmwk_reg && I_CONTROLLER_ENABLE_BIT && !rsm_end |=> rmwk_reg)
    else $error("remote wake bit dropped before resume end");
  a_resume_flags: assert property (
    I_CONTROLLER_ENABLE_BIT && rsm_start |=> gen_reg.up_resume && !gen_reg.suspend ##0 O_RESUME_DRV)
    else $error("resume start did not update flags");
  a_stall_sets_flag: assert property (
    I_CONTROLLER_ENABLE_BIT && hsk_next == udec_pkg::HSK_STALL |=> st_reg[$past(I_TOK.ep)].flags.stall_sent
      && !($rose(st_reg[$past(I_TOK.ep)].flags.out_rx)))
    else $error("stall sent without flag");
  a_detach_pullup: assert property (
    I_CONTROLLER_ENABLE_BIT && I_DETACH_WR |=> O_PULLUP_EN == !$past(I_DETACH_VAL))
    else $error("pull-up does not follow detach");
  a_suspend_time: assert property (
    I_CONTROLLER_ENABLE_BIT && susp_hit |=> gen_reg.suspend ##1 O_GEN_FLAGS.suspend)
    else $error("suspend flag not set after idle time");

  c_setup_ack:  cover property (O_HSK_VALID && O_HSK == udec_pkg::HSK_ACK && st_reg[0].flags.setup_rx);
  c_stall_sent: cover property (O_HSK == udec_pkg::HSK_STALL);
  c_suspend:    cover property ($rose(gen_reg.suspend));
  c_resume:     cover property ($rose(O_RESUME_DRV));
endmodule : udec_ctrl

// >>> hdl/udec_pkg.sv
/*
  Constants, types and timing figures shared by the endpoint control block.
  Assumes a single 250 MHz clock and a same-clock packet engine upstream.
*/
// Notes on behaviour
// - Endpoint reset bit clears state, banks, flags and status; toggle and config kept.
// - Bus reset (SE0 100 us) disables endpoints, keeps control config, clears its toggle.
// - Optional CPU reset on bus reset; controller stays enabled after it.
// - Three-bit endpoint select routes every endpoint access except the per-endpoint reset bits, interrupt lines and the shared interrupt enables.
// - Endpoint held in reset while its enable bit is clear.
// - Config valid only when size fits RAM; only control SETUP answered before that.
// - Disabling an endpoint resets it and its toggle, keeps size, banks, reserve.
// - Address enable clear answers address 00h only, else only stored address.
// - Address resets to 00h; address enable cleared by reset, bus reset, disable.
// - Three ms of idle J sets suspend flag and its interrupt.
// - Line activity sets wake flag; wake and suspend flags clear each other.
// - Detach resets to one; set drops D+ pull-up, clear restores it.
// - Remote wake allowed only in suspend; resume starts after 5 ms idle.
// - Resume start sets resume flag, clears suspend; end clears wake bit.
// - Stall request answers STALL until stall clear; clear bit reads zero.
// - Each STALL sets stall-sent flag; packet discarded, no OUT or access flag.
// - SETUP on a control endpoint always acknowledged; sets setup flag, clears stall, stall-sent, IN-ready.
// - Pending retry answers before STALL.
// - Control SETUP never sets OUT flag; handover and access read zero.
// - First control-read status token NAKed; CPU data dropped, IN-ready clear ignored.
// - Control-read OUT retry acknowledged, sets OUT and IN-ready; ZLP zeroes count.
// - Clearing controller enable resets the controller except the line sync and the idle and SE0 timers.
// - Remote wake bit cleared only by hardware.
// - CPU-reset option bit cleared by a zero write or controller disable, not by bus reset.
package udec_pkg;
  localparam int EP_NUM       = 5;
  localparam int EP_W         = 3;
  localparam int ADDR_W       = 7;
  localparam int LEN_W        = 7;
  localparam int CNT_W        = 22;
  localparam int CLK_MHZ      = 250;
  localparam int BUS_RST_US   = 100;
  localparam int SUSP_MS      = 3;
  localparam int RWK_MS       = 5;
  localparam int RESUME_MS    = 2;
  localparam int US_PER_MS    = 1000;
  localparam int BUS_RST_CYC  = BUS_RST_US * CLK_MHZ;
  localparam int SUSP_CYC     = SUSP_MS * US_PER_MS * CLK_MHZ;
  localparam int RWK_CYC      = RWK_MS * US_PER_MS * CLK_MHZ;
  localparam int RESUME_CYC   = RESUME_MS * US_PER_MS * CLK_MHZ;
  localparam int DPRAM_BYTES  = 176;
  localparam logic [8:0] EP_MIN_BYTES = 9'h008;
  localparam logic [ADDR_W-1:0] ADDR_DEFAULT = 7'h00;
  localparam logic [1:0] LINE_J   = 2'h2;
  localparam logic [1:0] LINE_SE0 = 2'h0;

  typedef enum logic [1:0] {PID_SETUP, PID_OUT, PID_IN} udec_pid_t;
  typedef enum logic [1:0] {HSK_NONE, HSK_ACK, HSK_NAK, HSK_STALL} udec_hsk_t;
  typedef enum logic [1:0] {CTL_IDLE, CTL_READ, CTL_STATUS} udec_ctl_t;

  typedef struct packed {
    logic setup_rx;
    logic out_rx;
    logic in_ready;
    logic stall_sent;
    logic nak_in;
  } udec_epflg_t;

  typedef struct packed {
    logic suspend;
    logic wake;
    logic up_resume;
    logic end_resume;
  } udec_genflg_t;

  typedef struct packed {
    logic             valid;
    udec_pid_t        pid;
    logic [EP_W-1:0]  ep;
    logic [ADDR_W-1:0] addr;
    logic             zlp;
    logic [LEN_W-1:0] len;
    logic             retry;
    logic             setup_in;
  } udec_tok_t;

  typedef struct packed {
    logic       ctrl;
    logic       memory_reserve_bit;
    logic       banks2;
    logic [2:0] size;
  } udec_cfgw_t;

  typedef struct packed {
    udec_cfgw_t w;
    logic       ok;
  } udec_cfg_t;

  typedef struct packed {
    udec_epflg_t      flags;
    logic             toggle;
    logic             stall;
    udec_ctl_t        cst;
    logic [LEN_W-1:0] bcnt;
  } udec_ep_t;

  typedef struct packed {
    logic             enabled;
    logic             cfg_ok;
    logic             toggle;
    logic             stall_rq;
    logic             bank_access;
    logic             handover;
    logic [LEN_W-1:0] bcnt;
  } udec_sts_t;

  // Bytes reserved by one configuration, both banks counted
  function automatic logic [8:0] ep_bytes(input udec_cfgw_t c);
    logic [8:0] one;
    one = EP_MIN_BYTES << c.size;
    return c.banks2 ? 9'(one << 1) : one;
  endfunction : ep_bytes
endpackage : udec_pkg

// >>> hdl/udec_sync3.sv
/*
  Three-stage synchroniser for line pins.
  Assumes asynchronous inputs; output moves only when stages two and three agree.
*/
module udec_sync3 #(
  parameter int W = 2
) (
  input  wire logic         i_clk,
  input  wire logic         i_nrst,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      o_q    <= '0;
    end else begin
      s1_reg <= i_d;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        o_q <= s3_reg;
      end
    end
  end
endmodule : udec_sync3
